// File: rsd_register_space_decoder.sv
// Register space decoder: register RAM, remappable program-side RAM,
// and control region passthrough for one 4096-byte register space.
// Assumes the core issues one access per cycle with synchronous reads.
// Assumes the map select changes only while both buses are idle.
// Register RAM size follows RAM_KB, which must be 1 or 2.
//
// Operation
// - The register space has 4096 byte addresses split into RAM and control.
// - Reads return the named source register and writes update destinations.
// - Addresses F00h to FFFh are decoded as the control register region.
// - Reads of reserved control addresses may return any value.
// - Register RAM starts at address 000h and is contiguous.
// - Register RAM size is a build parameter of 1 KB or 2 KB.
// - Between RAM and control, reads are undefined and writes are dropped.
// - Program-side RAM may map as register RAM just above register RAM.
`timescale 1ns/1ps
module rsd_register_space_decoder #(
   parameter int RAM_KB = 2
) (
   // Clock and reset
   input  wire logic                             core_clk_i,
   input  wire logic                             rst_n_i,
   // Mapping select: high puts program-side RAM in register space
   input  wire logic                             program_side_ram_in_regs_i,
   // Register access from the core
   input  wire logic                             reg_rd_i,
   input  wire logic                             reg_wr_i,
   input  wire logic [rsd_pkg::RSD_ADDR_W-1:0]   reg_addr_i,
   input  wire logic [rsd_pkg::RSD_DATA_W-1:0]   reg_wdata_i,
   output logic      [rsd_pkg::RSD_DATA_W-1:0]   reg_rdata_o,
   output logic                                  reg_rvalid_o,
   // Program memory access to program-side RAM
   input  wire logic                             prog_rd_i,
   input  wire logic                             prog_wr_i,
   input  wire logic [rsd_pkg::RSD_PROG_ADDR_W-1:0] prog_addr_i,
   input  wire logic [rsd_pkg::RSD_DATA_W-1:0]   prog_wdata_i,
   output logic      [rsd_pkg::RSD_DATA_W-1:0]   prog_rdata_o,
   output logic                                  prog_rvalid_o,
   output logic                                  prog_hit_o,
   // Control region toward peripherals
   output logic                                  ctrl_rd_o,
   output logic                                  ctrl_wr_o,
   output logic      [7:0]                       ctrl_addr_o,
   output logic      [rsd_pkg::RSD_DATA_W-1:0]   ctrl_wdata_o,
   input  wire logic [rsd_pkg::RSD_DATA_W-1:0]   ctrl_rdata_i,
   input  wire logic                             ctrl_impl_i
);
   import rsd_pkg::*;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int RAM_BYTES = RAM_KB * RSD_KB;
   localparam int RAM_AW    = $clog2(RAM_BYTES);
   localparam logic [RSD_ADDR_W:0] RAM_TOP =
      (RSD_ADDR_W+1)'(RAM_BYTES);
   // 1K build puts the window at 400h, 2K build at 800h
   localparam logic [RSD_ADDR_W:0] PROGRAM_SIDE_RAM_TOP =
      (RSD_ADDR_W+1)'(RAM_BYTES + RSD_PROGRAM_SIDE_RAM_BYTES);

   // Region of the access seen at the bus this cycle
   typedef enum logic [1:0] {
      RSD_SEL_NONE = 2'b00,
      RSD_SEL_RAM  = 2'b01,
      RSD_SEL_PROGRAM_SIDE_RAM = 2'b10,
      RSD_SEL_CTRL = 2'b11
   } rsd_sel_t;

   // Memories live here; neither is reset
   logic [RSD_DATA_W-1:0] ram_mem  [RAM_BYTES];
   logic [RSD_DATA_W-1:0] program_side_ram_mem [RSD_PROGRAM_SIDE_RAM_BYTES];

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire [RSD_ADDR_W:0] addr_ext = {1'b0, reg_addr_i};
   // Everything from the control base up to the top byte
   wire in_ctrl = reg_addr_i >= RSD_CTRL_BASE;
   wire in_ram  = addr_ext < RAM_TOP;
   wire below_program_side_ram_top = addr_ext < PROGRAM_SIDE_RAM_TOP;

   // Never decoded in both spaces at once
   wire in_program_side_ram = program_side_ram_in_regs_i && !in_ram && !in_ctrl
                  && below_program_side_ram_top;
   wire [RAM_AW-1:0] ram_idx = reg_addr_i[RAM_AW-1:0];
   wire [RSD_PROGRAM_SIDE_RAM_ADDR_W-1:0] program_side_ram_reg_idx =
      reg_addr_i[RSD_PROGRAM_SIDE_RAM_ADDR_W-1:0];

   wire [RSD_PROG_ADDR_W-1:0] prog_off = prog_addr_i - RSD_PROG_PROGRAM_SIDE_RAM_BASE;

   // Program window is one kilobyte from its base while not remapped
   wire prog_above = prog_addr_i >= RSD_PROG_PROGRAM_SIDE_RAM_BASE;
   wire prog_below = prog_off < RSD_PROG_ADDR_W'(RSD_PROGRAM_SIDE_RAM_BYTES);
   wire prog_in_program_side_ram = !program_side_ram_in_regs_i && prog_above && prog_below;
   wire [RSD_PROGRAM_SIDE_RAM_ADDR_W-1:0] program_side_ram_prog_idx =
      prog_off[RSD_PROGRAM_SIDE_RAM_ADDR_W-1:0];

   wire ram_we  = reg_wr_i && in_ram;
   wire program_side_ram_rwe = reg_wr_i && in_program_side_ram;
   wire program_side_ram_pwe = prog_wr_i && prog_in_program_side_ram;

   rsd_sel_t sel_now;
   assign sel_now = in_ctrl ? RSD_SEL_CTRL :
                    in_ram  ? RSD_SEL_RAM  :
                    in_program_side_ram ? RSD_SEL_PROGRAM_SIDE_RAM : RSD_SEL_NONE;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // RAM contents are not reset; reset value is undefined
   logic [RSD_DATA_W-1:0] ram_q;
   logic [RSD_DATA_W-1:0] program_side_ram_rq;
   logic [RSD_DATA_W-1:0] program_side_ram_pq;

   // Read every cycle; a byte written is seen by a read one cycle on
   always_ff @(posedge core_clk_i) begin
      if (ram_we) begin
         ram_mem[ram_idx] <= reg_wdata_i;
      end
      ram_q <= ram_mem[ram_idx];
   end

   // Only one port can be live since the select is exclusive
   // Register port wins a clash, though the map select rules one out
   always_ff @(posedge core_clk_i) begin
      if (program_side_ram_rwe) begin
         program_side_ram_mem[program_side_ram_reg_idx] <= reg_wdata_i;
      end else if (program_side_ram_pwe) begin
         program_side_ram_mem[program_side_ram_prog_idx] <= prog_wdata_i;
      end
      program_side_ram_rq <= program_side_ram_mem[program_side_ram_reg_idx];
      program_side_ram_pq <= program_side_ram_mem[program_side_ram_prog_idx];
   end

   // ----------------------------------------------------------------
   // Control region strobes, registered
   // ----------------------------------------------------------------
   // Reserved writes are forwarded; peripherals decide what happens
   // Address and data follow the bus each cycle; only strobes qualify
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ctrl_rd_o    <= 1'b0;
         ctrl_wr_o    <= 1'b0;
         ctrl_addr_o  <= 8'h00;
         ctrl_wdata_o <= 8'h00;
      end else begin
         ctrl_rd_o    <= reg_rd_i && in_ctrl;
         ctrl_wr_o    <= reg_wr_i && in_ctrl;
         ctrl_addr_o  <= reg_addr_i[7:0];
         ctrl_wdata_o <= reg_wdata_i;
      end
   end

   // ----------------------------------------------------------------
   // Control read data
   // ----------------------------------------------------------------
   // Taken off the bus in the answer cycle itself: by then sel_reg
   // already holds the region of the next access
   wire [RSD_DATA_W-1:0] ctrl_rsel = ctrl_impl_i ? ctrl_rdata_i
                                                 : RSD_UNDEF_DATA;

   // ----------------------------------------------------------------
   // Read return
   // ----------------------------------------------------------------
   // Select and strobe of the access whose data is in flight
   rsd_sel_t sel_reg;
   logic     rd_reg;
   logic     prd_reg;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         sel_reg <= RSD_SEL_NONE;
         rd_reg  <= 1'b0;
         prd_reg <= 1'b0;
      end else begin
         sel_reg <= sel_now;
         rd_reg  <= reg_rd_i;
         prd_reg <= prog_rd_i && prog_in_program_side_ram;
      end
   end

   // Control data arrives one cycle after the registered strobe
   logic [RSD_DATA_W-1:0] rdata_next;
   always_comb begin
      case (sel_reg)
         RSD_SEL_RAM:  rdata_next = ram_q;
         RSD_SEL_PROGRAM_SIDE_RAM: rdata_next = program_side_ram_rq;
         RSD_SEL_CTRL: rdata_next = ctrl_rsel;
         default:      rdata_next = RSD_UNDEF_DATA;
      endcase
   end

   logic                  rd2_reg;
   logic [RSD_DATA_W-1:0] rdata_hold;
   logic                  ctrl_pend;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o   <= 8'h00;
         reg_rvalid_o  <= 1'b0;
         prog_rdata_o  <= 8'h00;
         prog_rvalid_o <= 1'b0;
         prog_hit_o    <= 1'b0;
         rd2_reg       <= 1'b0;
         rdata_hold    <= 8'h00;
         ctrl_pend     <= 1'b0;
      end else begin
         // Uniform three-cycle read latency for every region
         rd2_reg      <= rd_reg;
         ctrl_pend    <= rd_reg && sel_reg == RSD_SEL_CTRL;
         rdata_hold   <= rdata_next;
         reg_rvalid_o <= rd2_reg;
         reg_rdata_o  <= ctrl_pend ? ctrl_rsel : rdata_hold;
         prog_rvalid_o <= prd_reg;
         // Program misses answer FF so stale data never leaks
         prog_rdata_o  <= prd_reg ? program_side_ram_pq : RSD_UNDEF_DATA;
         // Hit flag follows every program address, strobe or not
         prog_hit_o    <= prog_in_program_side_ram;
      end
   end

endmodule

// File: rsd_pkg.sv
// Package for the register space decoder: address map and sizes.
// Assumes a 12-bit byte address register file and 8-bit data.
package rsd_pkg;
   // ----------------------------------------------------------------
   // Address space
   // ----------------------------------------------------------------
   localparam int          RSD_ADDR_W      = 12;
   localparam int          RSD_DATA_W      = 8;
   localparam int          RSD_SPACE_BYTES = 4096;
   localparam logic [11:0] RSD_CTRL_BASE   = 12'hF00;
   localparam logic [11:0] RSD_RAM_BASE    = 12'h000;
   localparam int          RSD_KB          = 1024;
   localparam int          RSD_PROGRAM_SIDE_RAM_BYTES  = 1024;
   localparam int          RSD_PROGRAM_SIDE_RAM_ADDR_W = 10;
   localparam int          RSD_RAM_MAX     = 2048;
   localparam int          RSD_PROG_ADDR_W = 16;
   localparam logic [15:0] RSD_PROG_PROGRAM_SIDE_RAM_BASE = 16'hE000;
   localparam logic [7:0]  RSD_UNDEF_DATA  = 8'hFF;
endpackage

// File: rsd_chk.sv
// Port checker for the register space decoder.
// Assumes it is bound onto every decoder instance.
`timescale 1ns/1ps
module rsd_chk #(
   parameter int RAM_KB = 2
) (
   input wire logic        core_clk_i, rst_n_i, program_side_ram_in_regs_i,
   input wire logic        reg_rd_i, reg_wr_i, reg_rvalid_o, prog_rd_i,
   input wire logic        prog_rvalid_o, ctrl_rd_o, ctrl_wr_o, ctrl_impl_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [15:0] prog_addr_i,
   input wire logic [7:0]  reg_rdata_o, ctrl_addr_o, ctrl_rdata_i
);
   logic [12:0] top_w;
   logic        ctl_w, gap_w, phit_w;
   // Gap top moves up by 1K when program-side RAM joins
   assign top_w  = 13'(RAM_KB * 1024) + (program_side_ram_in_regs_i ? 13'h400 : 13'h0);
   assign ctl_w  = reg_addr_i[11:8] == 4'hF;
   assign gap_w  = {1'b0, reg_addr_i} >= top_w && !ctl_w;
   assign phit_w = prog_addr_i[15:10] == 6'h38 && !program_side_ram_in_regs_i;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   ctl_read_a: assert property (reg_rd_i && ctl_w |=> ctrl_rd_o &&
      ctrl_addr_o == $past(reg_addr_i[7:0])) else $error("ctrl read lost");
   ctl_write_a: assert property (reg_wr_i && ctl_w |=> ctrl_wr_o)
      else $error("ctrl write lost");
   ram_quiet_a: assert property ((reg_rd_i || reg_wr_i) && !ctl_w
      |=> !ctrl_rd_o && !ctrl_wr_o) else $error("ctrl strobe on ram");
   rd_latency_a: assert property (reg_rd_i |-> ##3 reg_rvalid_o)
      else $error("read answer late");
   rvalid_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i, 3))
      else $error("read answer unasked");
   gap_read_a: assert property (reg_rd_i && gap_w |-> ##3
      reg_rdata_o == 8'hFF) else $error("gap read not FF");
   ctl_data_a: assert property (reg_rd_i && ctl_w ##2 ctrl_impl_i |=>
      reg_rdata_o == $past(ctrl_rdata_i)) else $error("ctrl data lost");
   unimpl_a: assert property (reg_rd_i && ctl_w ##2 !ctrl_impl_i |=>
      reg_rdata_o == 8'hFF) else $error("reserved read not FF");
   prog_hit_a: assert property (prog_rd_i && phit_w |-> ##2
      prog_rvalid_o) else $error("program read lost");
   prog_excl_a: assert property (prog_rd_i && program_side_ram_in_regs_i |-> ##2
      !prog_rvalid_o) else $error("ram seen in both spaces");
endmodule
bind rsd_register_space_decoder rsd_chk #(.RAM_KB(RAM_KB)) chk_u (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i),
   .program_side_ram_in_regs_i(program_side_ram_in_regs_i), .reg_wr_i(reg_wr_i),
   .reg_rvalid_o(reg_rvalid_o), .prog_rd_i(prog_rd_i),
   .prog_rvalid_o(prog_rvalid_o), .ctrl_rd_o(ctrl_rd_o),
   .ctrl_wr_o(ctrl_wr_o), .ctrl_impl_i(ctrl_impl_i), .reg_addr_i(reg_addr_i),
   .prog_addr_i(prog_addr_i), .reg_rdata_o(reg_rdata_o),
   .ctrl_addr_o(ctrl_addr_o), .ctrl_rdata_i(ctrl_rdata_i));

// File: rsd_periph_model.sv
// Peripheral responder behind the control region.
// Assumes read data is taken the cycle after ctrl_rd_o.
`timescale 1ns/1ps
module rsd_periph_model (
   input  wire logic       core_clk_i,
   input  wire logic       ctrl_rd_o,
   input  wire logic [7:0] ctrl_addr_o,
   output logic      [7:0] ctrl_rdata_i = 8'h00,
   output logic            ctrl_impl_i = 1'b0
);
   logic [7:0] spin_reg = 8'h00;
   // Low half implemented; idle bus churns so stale data cannot pass
   always @(posedge core_clk_i) begin
      spin_reg     <= spin_reg + 8'h35;
      ctrl_impl_i  <= ctrl_rd_o && !ctrl_addr_o[7];
      ctrl_rdata_i <= ctrl_rd_o ? ~ctrl_addr_o : spin_reg;
   end
endmodule

// File: test_register_space_decoder.sv
// Self-checking bench for the register space decoder, 2K build.
// Assumes the checker and peripheral model are compiled first.
`timescale 1ns/1ps
module test_register_space_decoder;
   logic        core_clk_i = 0, rst_n_i = 0, program_side_ram_in_regs_i = 0;
   logic        reg_rd_i = 0, reg_wr_i = 0, prog_rd_i = 0, prog_wr_i = 0;
   logic [11:0] reg_addr_i = 0;
   logic [15:0] prog_addr_i = 0;
   logic [7:0]  reg_wdata_i = 0, prog_wdata_i = 0, reg_rdata_o, prog_rdata_o;
   logic [7:0]  ctrl_addr_o, ctrl_wdata_o, ctrl_rdata_i;
   logic        reg_rvalid_o, prog_rvalid_o, prog_hit_o;
   logic        ctrl_rd_o, ctrl_wr_o, ctrl_impl_i;
   int          failures = 0, n_tests = 0;
   rsd_register_space_decoder #(.RAM_KB(2)) dut_u (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .program_side_ram_in_regs_i(program_side_ram_in_regs_i), .reg_rd_i(reg_rd_i),
      .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .prog_rd_i(prog_rd_i),
      .prog_wr_i(prog_wr_i), .prog_addr_i(prog_addr_i),
      .prog_wdata_i(prog_wdata_i), .prog_rdata_o(prog_rdata_o),
      .prog_rvalid_o(prog_rvalid_o), .prog_hit_o(prog_hit_o),
      .ctrl_rd_o(ctrl_rd_o), .ctrl_wr_o(ctrl_wr_o),
      .ctrl_addr_o(ctrl_addr_o), .ctrl_wdata_o(ctrl_wdata_o),
      .ctrl_rdata_i(ctrl_rdata_i), .ctrl_impl_i(ctrl_impl_i));
   rsd_periph_model peri_u (.core_clk_i(core_clk_i), .ctrl_rd_o(ctrl_rd_o),
      .ctrl_addr_o(ctrl_addr_o), .ctrl_rdata_i(ctrl_rdata_i),
      .ctrl_impl_i(ctrl_impl_i));
   always #20 core_clk_i = ~core_clk_i;
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      reg_rd_i    <= !w;
      reg_wr_i    <= w;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(negedge core_clk_i);
      reg_rd_i <= 0;
      reg_wr_i <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      int k = 0;
      acc(0, a, 8'h00);
      while (reg_rvalid_o !== 1'b1 && k < 8) begin
         @(negedge core_clk_i);
         k++;
      end
      chk({7'h0, reg_rvalid_o}, 8'h01);
      chk(reg_rdata_o, e);
   endtask
   // Program port access; hit flag checked a cycle on, data two on
   task automatic pacc(input logic w, input logic [15:0] a, input logic h,
                       input logic [7:0] e);
      @(negedge core_clk_i);
      prog_rd_i    <= !w;
      prog_wr_i    <= w;
      prog_addr_i  <= a;
      prog_wdata_i <= e;
      @(negedge core_clk_i);
      prog_rd_i <= 0;
      prog_wr_i <= 0;
      chk({7'h0, prog_hit_o}, {7'h0, h});
      @(negedge core_clk_i);
      if (!w) begin
         chk({7'h0, prog_rvalid_o}, {7'h0, h});
         chk(prog_rdata_o, e);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(negedge core_clk_i);
      rst_n_i <= 1;
      acc(1, 12'h000, 8'hA5);
      acc(1, 12'h7FF, 8'h3C);
      rd(12'h000, 8'hA5);
      rd(12'h7FF, 8'h3C);
      acc(1, 12'h800, 8'h11);
      rd(12'h800, 8'hFF);
      rd(12'hEFF, 8'hFF);
      $display("ram and gap test done");
      program_side_ram_in_regs_i <= 1;
      acc(1, 12'h800, 8'h5A);
      acc(1, 12'hBFF, 8'hC3);
      rd(12'h800, 8'h5A);
      rd(12'hBFF, 8'hC3);
      rd(12'hC00, 8'hFF);
      pacc(0, 16'hE000, 1'b0, 8'hFF);
      program_side_ram_in_regs_i <= 0;
      pacc(1, 16'hE3FF, 1'b1, 8'h77);
      pacc(0, 16'hE3FF, 1'b1, 8'h77);
      rd(12'h800, 8'hFF);
      $display("remap test done");
      acc(1, 12'hF00, 8'h9E);
      chk({ctrl_wr_o, 7'h0}, 8'h80);
      chk(ctrl_wdata_o, 8'h9E);
      chk(ctrl_addr_o, 8'h00);
      rd(12'hF10, 8'hEF);
      rd(12'hFFF, 8'hFF);
      $display("control test done");
      wrap_up;
   end
   initial begin
      repeat (3000) @(posedge core_clk_i);
      failures++;
      wrap_up;
   end
endmodule
